// [common/crsf_pkg.sv]
package crsf_pkg;

  // apb word offsets
  localparam logic [7:0] OFS_GPR_BASE = 8'h00; // eight words to 8'h1c
  localparam logic [7:0] OFS_SEG_BASE = 8'h20; // four words to 8'h2c
  localparam logic [7:0] OFS_FLAGS    = 8'h30;
  localparam logic [7:0] OFS_PCB      = 8'h34;

  // general register indices
  localparam logic [2:0] GPR_ACC   = 3'h0; // accumulator_word
  localparam logic [2:0] GPR_COUNT = 3'h1; // count_word
  localparam logic [2:0] GPR_IO    = 3'h2; // io_port_word
  localparam logic [2:0] GPR_BASE  = 3'h3; // translate_base_word
  localparam logic [2:0] GPR_SPLIT = 3'h4; // below this, byte halves exist

  // segment register indices
  localparam logic [1:0] SEG_CODE  = 2'h0;
  localparam logic [1:0] SEG_DATA  = 2'h1;
  localparam logic [1:0] SEG_STACK = 2'h2;
  localparam logic [1:0] SEG_EXTRA = 2'h3;

  // status word bit positions
  localparam int FLG_CARRY = 0;
  localparam int FLG_PAR   = 2;
  localparam int FLG_AUX   = 4;
  localparam int FLG_ZERO  = 6;
  localparam int FLG_SIGN  = 7;
  localparam int FLG_STEP  = 8;
  localparam int FLG_IEN   = 9;
  localparam int FLG_DIR   = 10;
  localparam int FLG_OVF   = 11;
  localparam logic [15:0] FLAGS_RW_MASK = 16'h0fd5;

  // reset values
  localparam logic [15:0] CODE_SEG_RESET = 16'hffff;
  localparam logic [15:0] SEG_RESET      = 16'h0000;
  localparam logic [15:0] IP_RESET       = 16'h0000;
  localparam logic [15:0] FLAGS_RESET    = 16'h0000;
  // relocation word: bit 12 memory space, bits 11:0 base bits 19:8
  localparam int          PCB_MEM_BIT    = 12;
  localparam logic [12:0] PCB_RESET      = 13'h00ff;
  localparam logic [12:0] PCB_RW_MASK    = 13'h1fff;

  // flag commands from the sequencer
  typedef enum logic [2:0] {
    CRSF_CMD_NONE, CRSF_CMD_SET_DIR, CRSF_CMD_CLR_DIR,
    CRSF_CMD_SET_IEN, CRSF_CMD_CLR_IEN
  } crsf_cmd_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } crsf_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } crsf_apb_rsp_t;

  typedef struct packed {
    logic        en;
    logic [2:0]  sel;
    logic        byte_op;
    logic        high;
    logic [15:0] data;
  } crsf_gpr_wr_t;

  typedef struct packed {
    logic        valid;
    logic        sub;
    logic        use_carry;
    logic        byte_op;
    logic [15:0] op_a;
    logic [15:0] op_b;
  } crsf_alu_req_t;

  typedef struct packed {
    logic [7:0][15:0] gpr;
    logic [3:0][15:0] seg;
    logic [15:0]      ip;
    logic [15:0]      flags;
    logic [12:0]      peripheral_control_block;
    logic             step_skip;
    logic             trap;
    logic [19:0]      phys;
    logic             phys_valid;
    logic [15:0]      alu_res;
    logic             alu_valid;
    logic [31:0]      prdata;
    logic             pslverr;
    logic [1:0]       irq_sync;
  } crsf_state_t;

  // segment shifted by four plus offset, carry past bit 19 dropped
  function automatic logic [19:0] crsf_phys(input logic [15:0] seg,
                                            input logic [15:0] off);
    crsf_phys = {seg, 4'h0} + {4'h0, off};
  endfunction : crsf_phys

endpackage : crsf_pkg

// [rtl/crsf_regs.sv]
`timescale 1ns/1ps

// Behaviour
// - eight 16-bit registers; first four also writable as byte halves
// - four 16-bit segment bases: code, data, stack, extra
// - code segment resets to ffff and serves as fetch base
// - data, stack and extra segments reset to zero
// - instruction pointer resets to zero, first fetch at ffff0
// - no bus path to the pointer; only fetch logic moves it
// - overflow flag bit 11 set on signed overflow
// - direction flag bit 10 set means string addresses step up
// - interrupt enable bit 9 gates maskable requests
// - step flag bit 8 traps per instruction, delayed after pop
// - sign flag bit 7 copies result msb
// - zero flag bit 6 set when result is zero
// - aux carry bit 4 marks carry or borrow at low nibble
// - parity bit 2 set when low result byte has even ones
// - carry bit 0 marks carry out or borrow into msb
// - count low byte gives shift amount, full word gives loops
// - io word gives port address, pairs with accumulator for mul/div
// - 20-bit physical address from segment and offset
// - control block base ff00 in io space until relocated
module crsf_regs
  import crsf_pkg::*;
(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          reset,
  // register bus
  input  wire crsf_apb_req_t apb_req,
  output crsf_apb_rsp_t      apb_rsp,
  // general register ports
  input  wire crsf_gpr_wr_t  gpr_wr,
  input  wire logic [2:0]    gpr_rd_sel,
  input  wire logic          gpr_rd_byte,
  input  wire logic          gpr_rd_high,
  output logic [15:0]        gpr_rd_data,
  input  wire logic          muldiv_wr,
  input  wire logic [15:0]   muldiv_lo,
  input  wire logic [15:0]   muldiv_hi,
  // segment write and address generation
  input  wire logic          seg_wr_en,
  input  wire logic [1:0]    seg_wr_sel,
  input  wire logic [15:0]   seg_wr_data,
  input  wire logic          agu_valid,
  input  wire logic [1:0]    agu_seg_sel,
  input  wire logic [15:0]   agu_offset,
  output logic [19:0]        phys_addr,
  output logic               phys_valid,
  // fetch pointer
  input  wire logic          ip_adv_en,
  input  wire logic [2:0]    ip_adv_len,
  input  wire logic          ip_load_en,
  input  wire logic [15:0]   ip_load_val,
  output logic [19:0]        fetch_addr,
  // arithmetic and flags
  input  wire crsf_alu_req_t alu_req,
  output logic [15:0]        alu_result,
  output logic               alu_valid,
  input  wire crsf_cmd_t     flag_cmd,
  input  wire logic          flags_pop_en,
  input  wire logic [15:0]   flags_pop_data,
  input  wire logic          instr_done,
  output logic [15:0]        flags_word,
  output logic               step_trap,
  // interrupt gating and operand taps
  input  wire logic          maskable_irq,
  output logic               irq_accept,
  output logic               string_addr_up,
  output logic [7:0]         shift_count_byte,
  output logic [15:0]        loop_count,
  output logic [15:0]        io_port_addr,
  // control block placement
  output logic               pcb_in_memory,
  output logic [19:0]        pcb_base
);

  crsf_state_t q;
  crsf_state_t d;

  // bus phase and decode
  logic        apb_setup;
  logic        apb_write;
  logic        hit_gpr;
  logic        hit_seg;
  logic        hit_flags;
  logic        hit_pcb;
  logic        hit_any;
  logic [2:0]  idx_gpr;
  logic [1:0]  idx_seg;

  assign apb_setup = apb_req.psel & ~apb_req.penable;
  assign apb_write = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign idx_gpr   = apb_req.paddr[4:2];
  assign idx_seg   = apb_req.paddr[3:2];
  assign hit_gpr   = apb_req.paddr[7:5] == OFS_GPR_BASE[7:5]
                     && apb_req.paddr[1:0] == 2'h0;
  assign hit_seg   = apb_req.paddr[7:4] == OFS_SEG_BASE[7:4]
                     && apb_req.paddr[1:0] == 2'h0;
  assign hit_flags = apb_req.paddr == OFS_FLAGS;
  assign hit_pcb   = apb_req.paddr == OFS_PCB;
  assign hit_any   = hit_gpr | hit_seg | hit_flags | hit_pcb;

  // adder operands, widened so both widths share one carry chain
  logic [16:0] wa;
  logic [16:0] wb;
  logic [16:0] sum;
  logic        cin;
  logic        res_msb;
  logic        a_msb;
  logic        b_msb;
  logic        ovf;
  logic        cy;

  always_comb begin
    cin = alu_req.use_carry & q.flags[FLG_CARRY];
    if (alu_req.byte_op) begin
      wa = {9'h0, alu_req.op_a[7:0]};
      wb = {9'h0, alu_req.op_b[7:0]};
    end else begin
      wa = {1'b0, alu_req.op_a};
      wb = {1'b0, alu_req.op_b};
    end
    if (alu_req.sub) begin
      sum = wa - wb - {16'h0000, cin};
    end else begin
      sum = wa + wb + {16'h0000, cin};
    end
    res_msb = alu_req.byte_op ? sum[7] : sum[15];
    a_msb   = alu_req.byte_op ? wa[7] : wa[15];
    b_msb   = alu_req.byte_op ? wb[7] : wb[15];
    cy      = alu_req.byte_op ? sum[8] : sum[16];
    if (alu_req.sub) begin
      ovf = (a_msb != b_msb) && (res_msb != a_msb);
    end else begin
      ovf = (a_msb == b_msb) && (res_msb != a_msb);
    end
  end

  // next-state: bus first, then datapath writes override
  always_comb begin
    d = q;
    d.irq_sync = {q.irq_sync[0], maskable_irq};
    d.trap = 1'b0;
    d.phys_valid = 1'b0;
    d.alu_valid = 1'b0;

    // read data is latched in setup so it is steady in access
    if (apb_setup) begin
      d.prdata = 32'h0000_0000;
      d.pslverr = ~hit_any;
      if (hit_gpr) begin
        d.prdata = {16'h0000, q.gpr[idx_gpr]};
      end else if (hit_seg) begin
        d.prdata = {16'h0000, q.seg[idx_seg]};
      end else if (hit_flags) begin
        d.prdata = {16'h0000, q.flags & FLAGS_RW_MASK};
      end else if (hit_pcb) begin
        d.prdata = {19'h0, q.peripheral_control_block};
      end
    end

    // bus writes; unmapped writes change nothing
    if (apb_write) begin
      if (hit_gpr) begin
        d.gpr[idx_gpr] = apb_req.pwdata[15:0];
      end else if (hit_seg) begin
        d.seg[idx_seg] = apb_req.pwdata[15:0];
      end else if (hit_flags) begin
        d.flags = apb_req.pwdata[15:0] & FLAGS_RW_MASK;
      end else if (hit_pcb) begin
        d.peripheral_control_block = apb_req.pwdata[12:0] & PCB_RW_MASK;
      end
    end

    if (gpr_wr.en) begin
      if (!gpr_wr.byte_op) begin
        d.gpr[gpr_wr.sel] = gpr_wr.data;
      end else if (gpr_wr.sel < GPR_SPLIT) begin
        if (gpr_wr.high) begin
          d.gpr[gpr_wr.sel][15:8] = gpr_wr.data[7:0];
        end else begin
          d.gpr[gpr_wr.sel][7:0] = gpr_wr.data[7:0];
        end
      end
    end

    if (muldiv_wr) begin
      d.gpr[GPR_ACC] = muldiv_lo;
      d.gpr[GPR_IO]  = muldiv_hi;
    end

    if (seg_wr_en) begin
      d.seg[seg_wr_sel] = seg_wr_data;
    end

    // pointer moved only by fetch and branch logic
    if (ip_load_en) begin
      d.ip = ip_load_val;
    end else if (ip_adv_en) begin
      d.ip = q.ip + {13'h0, ip_adv_len};
    end

    if (agu_valid) begin
      d.phys = crsf_phys(q.seg[agu_seg_sel], agu_offset);
      d.phys_valid = 1'b1;
    end

    case (flag_cmd)
      CRSF_CMD_SET_DIR: d.flags[FLG_DIR] = 1'b1;
      CRSF_CMD_CLR_DIR: d.flags[FLG_DIR] = 1'b0;
      CRSF_CMD_SET_IEN: d.flags[FLG_IEN] = 1'b1;
      CRSF_CMD_CLR_IEN: d.flags[FLG_IEN] = 1'b0;
      default: ;
    endcase

    // pop restores the word and may defer the first trap
    if (flags_pop_en) begin
      d.flags = flags_pop_data & FLAGS_RW_MASK;
    end
    if (flags_pop_en && !instr_done && !q.flags[FLG_STEP]
        && flags_pop_data[FLG_STEP]) begin
      d.step_skip = 1'b1;
    end else if (instr_done) begin
      d.step_skip = 1'b0;
    end
    // trap at end of each traced instruction unless a pop deferred it
    d.trap = instr_done & q.flags[FLG_STEP] & ~q.step_skip;

    // arithmetic status wins over any other write in the same cycle
    if (alu_req.valid) begin
      d.alu_res = alu_req.byte_op ? {8'h00, sum[7:0]} : sum[15:0];
      d.alu_valid = 1'b1;
      d.flags[FLG_CARRY] = cy;
      d.flags[FLG_OVF] = ovf;
      d.flags[FLG_SIGN] = res_msb;
      d.flags[FLG_ZERO] = alu_req.byte_op ? (sum[7:0] == 8'h00)
                                          : (sum[15:0] == 16'h0000);
      // nibble carry from the operand and sum bits
      d.flags[FLG_AUX] = wa[4] ^ wb[4] ^ sum[4];
      // even parity of the low byte
      d.flags[FLG_PAR] = ~^sum[7:0];
    end
  end

  // single state register
  always_ff @(posedge clock) begin
    if (reset) begin
      q <= '0;
      q.seg[SEG_CODE] <= CODE_SEG_RESET;
      q.seg[SEG_DATA] <= SEG_RESET;
      q.seg[SEG_STACK] <= SEG_RESET;
      q.seg[SEG_EXTRA] <= SEG_RESET;
      q.ip <= IP_RESET;
      q.flags <= FLAGS_RESET;
      q.peripheral_control_block <= PCB_RESET;
    end else begin
      q <= d;
    end
  end

  // bus answer: zero wait states
  assign apb_rsp.prdata  = q.prdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = q.pslverr & apb_req.psel & apb_req.penable;

  always_comb begin
    if (gpr_rd_byte && gpr_rd_sel < GPR_SPLIT) begin
      gpr_rd_data = gpr_rd_high ? {8'h00, q.gpr[gpr_rd_sel][15:8]}
                                : {8'h00, q.gpr[gpr_rd_sel][7:0]};
    end else begin
      gpr_rd_data = q.gpr[gpr_rd_sel];
    end
  end

  // shift amount and loop count taps
  assign shift_count_byte = q.gpr[GPR_COUNT][7:0];
  assign loop_count       = q.gpr[GPR_COUNT];
  assign io_port_addr     = q.gpr[GPR_IO];

  // fetch address from code segment and pointer
  assign fetch_addr = crsf_phys(q.seg[SEG_CODE], q.ip);
  assign phys_addr  = q.phys;
  assign phys_valid = q.phys_valid;

  assign alu_result = q.alu_res;
  assign alu_valid  = q.alu_valid;
  assign flags_word = q.flags;
  assign step_trap  = q.trap;

  // masked request gating after the synchroniser
  assign irq_accept = q.irq_sync[1] & q.flags[FLG_IEN];
  assign string_addr_up = q.flags[FLG_DIR];

  // control block placement; io space keeps base bits 19:16 as written
  assign pcb_in_memory = q.peripheral_control_block[PCB_MEM_BIT];
  assign pcb_base      = {q.peripheral_control_block[11:0], 8'h00};

endmodule : crsf_regs

// [sim/crsf_regs_asserts.sv]
`timescale 1ns/1ps
module crsf_regs_asserts
  import crsf_pkg::*;
(
  // clock and reset
  input wire logic          clock,
  input wire logic          reset,
  // register bus
  input wire crsf_apb_req_t apb_req,
  input wire crsf_apb_rsp_t apb_rsp,
  // datapath
  input wire logic          agu_valid,
  input wire logic          phys_valid,
  input wire crsf_alu_req_t alu_req,
  input wire logic [15:0]   alu_result,
  input wire logic          alu_valid,
  input wire logic          instr_done,
  input wire logic [15:0]   flags_word,
  input wire logic          step_trap,
  input wire logic          maskable_irq,
  input wire logic          irq_accept,
  input wire logic          string_addr_up,
  // placement
  input wire logic [19:0]   fetch_addr,
  input wire logic [19:0]   pcb_base,
  input wire logic          pcb_in_memory
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // word request followed by its answer
  sequence s_word_op;
    alu_req.valid && !alu_req.byte_op ##1 alu_valid;
  endsequence

  a_alu_answer: assert property (alu_req.valid |=> alu_valid)
    else $error("alu answer missing");
  a_zero_sign: assert property (s_word_op |->
    flags_word[FLG_ZERO] == (alu_result == 16'h0) &&
    flags_word[FLG_SIGN] == alu_result[15] &&
    flags_word[FLG_PAR] == ~^alu_result[7:0])
    else $error("result flags wrong");
  a_phys_pulse: assert property (agu_valid |=> phys_valid)
    else $error("address answer missing");
  a_phys_cause: assert property (phys_valid |-> $past(agu_valid))
    else $error("address without request");
  a_reserved_zero: assert property (
    (flags_word & ~FLAGS_RW_MASK) == 16'h0)
    else $error("reserved status bit set");
  a_dir_tap: assert property (
    string_addr_up == flags_word[FLG_DIR])
    else $error("direction tap wrong");
  a_irq_gate: assert property (irq_accept |->
    flags_word[FLG_IEN] && $past(maskable_irq, 2))
    else $error("interrupt accepted while blocked");
  a_trap_cause: assert property (step_trap |->
    $past(instr_done) && $past(flags_word[FLG_STEP]))
    else $error("trap without step");
  a_err_access: assert property (apb_rsp.pslverr |->
    apb_req.psel && apb_req.penable)
    else $error("error outside access");
  a_err_unmapped: assert property (
    apb_req.psel && apb_req.penable && apb_req.paddr > OFS_PCB
    |-> apb_rsp.pslverr)
    else $error("access past the map not refused");
  a_reset_state: assert property ($past(reset) |->
    fetch_addr == 20'hffff0 && pcb_base == 20'h0ff00 && !pcb_in_memory)
    else $error("state after reset wrong");
endmodule : crsf_regs_asserts

bind crsf_regs crsf_regs_asserts u_chk (
  .clock, .reset, .apb_req, .apb_rsp, .agu_valid, .phys_valid, .alu_req,
  .alu_result, .alu_valid, .instr_done, .flags_word, .step_trap,
  .maskable_irq, .irq_accept, .string_addr_up, .fetch_addr, .pcb_base,
  .pcb_in_memory
);

// [sim/crsf_regs_test.sv]
`timescale 1ns/1ps
module crsf_regs_test
  import crsf_pkg::*;
  ;
  logic          clock = 1'b0;
  logic          reset = 1'b1;
  crsf_apb_req_t apb_req = '0;
  crsf_apb_rsp_t apb_rsp;
  crsf_gpr_wr_t  gpr_wr = '0;
  crsf_alu_req_t alu_req = '0;
  crsf_cmd_t     flag_cmd = CRSF_CMD_NONE;
  logic [2:0]    gpr_rd_sel = 3'h0, ip_adv_len = 3'h0;
  logic [1:0]    seg_wr_sel = 2'h0, agu_seg_sel = 2'h0;
  logic [15:0]   muldiv_lo = 16'h0, muldiv_hi = 16'h0, seg_wr_data = 16'h0;
  logic [15:0]   agu_offset = 16'h0, ip_load_val = 16'h0;
  logic [15:0]   flags_pop_data = 16'h0;
  logic          gpr_rd_byte = 1'b0, gpr_rd_high = 1'b0, muldiv_wr = 1'b0;
  logic          seg_wr_en = 1'b0, agu_valid = 1'b0, ip_adv_en = 1'b0;
  logic          ip_load_en = 1'b0, flags_pop_en = 1'b0, instr_done = 1'b0;
  logic          maskable_irq = 1'b0;
  logic [15:0]   gpr_rd_data, alu_result, flags_word, loop_count;
  logic [15:0]   io_port_addr;
  logic [19:0]   phys_addr, fetch_addr, pcb_base;
  logic [7:0]    shift_count_byte;
  logic          phys_valid, alu_valid, step_trap, irq_accept;
  logic          string_addr_up, pcb_in_memory;
  int            fail_count = 0, comparisons = 0, cycles = 0;

  crsf_regs u_dut (
    .clock, .reset, .apb_req, .apb_rsp, .gpr_wr, .gpr_rd_sel, .gpr_rd_byte,
    .gpr_rd_high, .gpr_rd_data, .muldiv_wr, .muldiv_lo, .muldiv_hi,
    .seg_wr_en, .seg_wr_sel, .seg_wr_data, .agu_valid, .agu_seg_sel,
    .agu_offset, .phys_addr, .phys_valid, .ip_adv_en, .ip_adv_len,
    .ip_load_en, .ip_load_val, .fetch_addr, .alu_req, .alu_result,
    .alu_valid, .flag_cmd, .flags_pop_en, .flags_pop_data, .instr_done,
    .flags_word, .step_trap, .maskable_irq, .irq_accept, .string_addr_up,
    .shift_count_byte, .loop_count, .io_port_addr, .pcb_in_memory, .pcb_base
  );

  always #5 clock = ~clock;

  // hang guard: the run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compares %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one transfer; answer and read data taken at the edge ending the access
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] x,
                     input logic er);
    logic [31:0] q;
    logic        e;
    logic        r;
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clock);
      q = apb_rsp.prdata;
      e = apb_rsp.pslverr;
      r = apb_rsp.pready;
    end while (r !== 1'b1);
    apb_req <= '0;
    @(posedge clock);
    if (!w) chk(q, x);
    chk(e, er);
  endtask : bus

  task automatic t_reset();
    @(negedge clock);
    chk(flags_word, FLAGS_RESET);
    chk(fetch_addr, 20'hffff0);
    chk(pcb_base, 20'h0ff00);
    chk(pcb_in_memory, 1'b0);
    @(posedge clock);
    bus(1'b0, OFS_SEG_BASE, 0, 32'hffff, 0);
    for (int i = 1; i < 4; i++)
      bus(1'b0, OFS_SEG_BASE + 8'(4 * i), 0, 0, 0);
    bus(1'b0, OFS_PCB, 0, 32'h00ff, 0);
  endtask : t_reset

  task automatic t_gpr();
    for (int i = 0; i < 8; i++)
      bus(1'b1, OFS_GPR_BASE + 8'(4 * i), 32'h1111 * (i + 1), 0, 0);
    for (int i = 0; i < 8; i++) begin
      gpr_rd_sel <= 3'(i);
      @(negedge clock);
      chk(gpr_rd_data, 32'h1111 * (i + 1));
      @(posedge clock);
    end
    chk(shift_count_byte, 8'h22);
    chk(loop_count, 16'h2222);
    chk(io_port_addr, 16'h3333);
    // high half of accumulator, then a refused byte write to index 4
    gpr_wr <= '{1'b1, GPR_ACC, 1'b1, 1'b1, 16'h00ab};
    @(posedge clock);
    gpr_wr <= '{1'b1, GPR_SPLIT, 1'b1, 1'b0, 16'h0000};
    @(posedge clock);
    gpr_wr <= '0;
    gpr_rd_sel <= GPR_ACC;
    @(negedge clock);
    chk(gpr_rd_data, 16'hab11);
    @(posedge clock);
    // byte halves through the read port
    gpr_rd_byte <= 1'b1;
    gpr_rd_high <= 1'b1;
    @(negedge clock);
    chk(gpr_rd_data, 16'h00ab);
    @(posedge clock);
    gpr_rd_high <= 1'b0;
    @(negedge clock);
    chk(gpr_rd_data, 16'h0011);
    @(posedge clock);
    gpr_rd_byte <= 1'b0;
    bus(1'b0, OFS_GPR_BASE + 8'h10, 0, 32'h5555, 0);
    muldiv_wr <= 1'b1;
    muldiv_lo <= 16'hbeef;
    muldiv_hi <= 16'hcafe;
    @(posedge clock);
    muldiv_wr <= 1'b0;
    @(negedge clock);
    chk(gpr_rd_data, 16'hbeef);
    chk(io_port_addr, 16'hcafe);
    @(posedge clock);
  endtask : t_gpr

  task automatic t_flags();
    crsf_cmd_t   c[4] = '{CRSF_CMD_SET_DIR, CRSF_CMD_CLR_DIR,
                          CRSF_CMD_SET_IEN, CRSF_CMD_CLR_IEN};
    logic [15:0] x[4] = '{16'h0400, 16'h0000, 16'h0200, 16'h0000};
    maskable_irq <= 1'b1;
    bus(1'b1, OFS_FLAGS, 32'hffff, 0, 0);
    bus(1'b0, OFS_FLAGS, 0, 32'h0fd5, 0);
    bus(1'b1, OFS_FLAGS, 0, 0, 0);
    foreach (c[i]) begin
      flag_cmd <= c[i];
      @(posedge clock);
      flag_cmd <= CRSF_CMD_NONE;
      @(negedge clock);
      chk(string_addr_up, x[i][10]);
      chk(irq_accept, x[i][9]);
      @(posedge clock);
    end
  endtask : t_flags

  task automatic t_alu();
    // mode bit 0 subtract, bit 1 carry in, bit 2 byte; case 2 uses carry
    logic [15:0] oa[6] = '{16'h7fff, 16'hffff, 16'h0001, 16'h0000,
                           16'h8000, 16'h00ff};
    logic [2:0]  md[6] = '{3'h0, 3'h0, 3'h2, 3'h1, 3'h1, 3'h4};
    logic [15:0] rx[6] = '{16'h8000, 16'h0000, 16'h0003, 16'hffff,
                           16'h7fff, 16'h0000};
    logic [15:0] fx[6] = '{16'h0894, 16'h0055, 16'h0004, 16'h0095,
                           16'h0814, 16'h0055};
    foreach (oa[i]) begin
      alu_req <= '{1'b1, md[i][0], md[i][1], md[i][2], oa[i], 16'h0001};
      @(posedge clock);
      alu_req <= '0;
      @(negedge clock);
      chk(alu_valid, 1'b1);
      chk(md[i][2] ? alu_result[7:0] : alu_result, rx[i]);
      chk(flags_word & 16'h08d5, fx[i]);
      @(posedge clock);
    end
  endtask : t_alu

  task automatic t_agu();
    seg_wr_en <= 1'b1;
    seg_wr_sel <= SEG_DATA;
    seg_wr_data <= 16'h1234;
    @(posedge clock);
    seg_wr_sel <= SEG_EXTRA;
    seg_wr_data <= 16'hffff;
    @(posedge clock);
    seg_wr_en <= 1'b0;
    agu_valid <= 1'b1;
    agu_seg_sel <= SEG_DATA;
    agu_offset <= 16'h5678;
    @(posedge clock);
    agu_seg_sel <= SEG_EXTRA;
    agu_offset <= 16'hffff;
    @(negedge clock);
    chk(phys_addr, 20'h179b8);
    chk(phys_valid, 1'b1);
    @(posedge clock);
    agu_valid <= 1'b0;
    ip_adv_en <= 1'b1;
    ip_adv_len <= 3'h3;
    @(negedge clock);
    chk(phys_addr, 20'h0ffef);
    @(posedge clock);
    ip_load_en <= 1'b1;
    ip_load_val <= 16'h0010;
    @(negedge clock);
    chk(phys_valid, 1'b0);
    chk(fetch_addr, 20'hffff3);
    @(posedge clock);
    ip_load_en <= 1'b0;
    ip_adv_en <= 1'b0;
    @(negedge clock);
    chk(fetch_addr, 20'h00000);
    @(posedge clock);
    bus(1'b0, OFS_SEG_BASE + 8'h4, 0, 32'h1234, 0);
    // no pointer on the bus, misaligned refused too
    bus(1'b1, 8'h38, 32'h5, 0, 1);
    bus(1'b0, 8'h38, 0, 0, 1);
    bus(1'b0, 8'h02, 0, 0, 1);
    chk(fetch_addr, 20'h00000);
  endtask : t_agu

  task automatic t_step();
    flags_pop_en <= 1'b1;
    flags_pop_data <= 16'hf100;
    @(posedge clock);
    flags_pop_en <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      instr_done <= 1'b1;
      @(posedge clock);
      instr_done <= 1'b0;
      @(negedge clock);
      chk(step_trap, i > 0);
      chk(flags_word, 16'h0100);
      @(posedge clock);
    end
  endtask : t_step

  task automatic t_pcb();
    bus(1'b1, OFS_PCB, 32'h1abc, 0, 0);
    bus(1'b0, OFS_PCB, 0, 32'h1abc, 0);
    @(negedge clock);
    chk(pcb_in_memory, 1'b1);
    chk(pcb_base, 20'habc00);
    @(posedge clock);
  endtask : t_pcb

  // second reset after registers were written must restore defaults
  task automatic t_rerst();
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    chk(pcb_base, 20'h0ff00);
    chk(pcb_in_memory, 1'b0);
    chk(fetch_addr, 20'hffff0);
    @(posedge clock);
    bus(1'b0, OFS_SEG_BASE + 8'h4, 0, 0, 0);
    bus(1'b0, OFS_FLAGS, 0, 0, 0);
  endtask : t_rerst

  // main sequence
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset();
    $display("reset test ended");
    t_gpr();
    $display("general register test ended");
    t_flags();
    $display("flag command test ended");
    t_alu();
    $display("arithmetic test ended");
    t_agu();
    $display("address test ended");
    t_step();
    $display("single step test ended");
    t_pcb();
    $display("control block test ended");
    t_rerst();
    $display("second reset test ended");
    summarize();
  end
endmodule : crsf_regs_test
